// >>> hdl/asrs_top.sv
`timescale 1ns/10ps
module asrs_top #(
    parameter int TICK_CYCLES = asrs_pkg::ASRS_TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             busy_flag,
    output logic             complete_flag,
    output logic             timeout_flag,
    output logic             overflow_flag,
    output logic [asrs_pkg::ASRS_IDX_W-1:0] busy_bit_idx,
    output logic [asrs_pkg::ASRS_IDX_W-1:0] complete_bit_idx,
    output logic [asrs_pkg::ASRS_IDX_W-1:0] timeout_bit_idx,
    output logic [asrs_pkg::ASRS_IDX_W-1:0] overflow_bit_idx,
    output logic             cannot_execute_flag,
    output logic             invalid_value_flag,
    output logic             port_two_active_flag,
    output logic             search_done
);
    import asrs_pkg::*;

    localparam int TW = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);

    generate
        if (TICK_CYCLES < 2) begin : g_chk
            $error("TICK_CYCLES must be at least 2");
        end
    endgenerate

    logic [31:0]    ctrl, rx_cfg, term_cfg, tmo_cfg;
    logic [31:0]    map0, map1, scfg, pat0, pat1;
    logic [15:0]    result;
    logic [15:0]    mem [0:2*ASRS_WORDS-1];
    logic           bank;
    asrs_rx_state_t rx_state;
    asrs_sr_state_t sr_state;
    logic [7:0]     rx_cnt, prev_byte;
    logic           got_first, ict_err, fct_err, rx_bad;
    logic [TW-1:0]  tick_cnt;
    logic           tick;
    logic [16:0]    gap;
    logic           srch_perm_q, s_bad, s_rev, s_fend;
    logic [7:0]     s_pos, s_start, s_last;
    logic [3:0]     s_plen;
    logic [ASRS_PAT_MAX-1:0] lane_ok;

    // Bus decode
    logic       access, bus_wr, mem_hit;
    logic [7:0] widx;
    assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = access & wb_we_i;
    assign widx    = wb_adr_i[9:2];
    assign mem_hit = (widx[7:6] == ASRS_MEM_PAGE);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (din & m);
    endfunction

    // Receive configuration views
    logic       var_mode, swap, term2, rx_perm;
    logic [7:0] len_cfg, t0, t_last;
    logic [15:0] ict_lim, fct_lim;
    assign rx_perm  = ctrl[ASRS_CTRL_RX];
    assign var_mode = rx_cfg[ASRS_RXCFG_VAR];
    assign swap     = rx_cfg[ASRS_RXCFG_SWAP];
    assign term2    = rx_cfg[ASRS_RXCFG_TERM2];
    assign len_cfg  = rx_cfg[ASRS_RXCFG_LEN +: 8];
    assign t0       = term_cfg[ASRS_TERM_T0 +: 8];
    assign t_last   = term2 ? term_cfg[ASRS_TERM_T1 +: 8] : t0;
    assign ict_lim  = tmo_cfg[ASRS_TMO_ICT +: 16];
    assign fct_lim  = tmo_cfg[ASRS_TMO_FCT +: 16];

    // Start checks and per-byte decisions
    logic rx_cfg_bad, term_hit, ovf_hit, last_byte, rx_store, tmo_hit;
    assign rx_cfg_bad = (rx_cfg[ASRS_RXCFG_PORT +: 4] != ASRS_PORT_TWO)
                      | (len_cfg == 8'h00)
                      | (len_cfg > 8'(ASRS_MAX_BYTES));
    assign term_hit  = (rx_data == t_last)
                     & (~term2 | ((rx_cnt != 8'h00) & (prev_byte == t0)));
    assign ovf_hit   = var_mode & (rx_cnt == len_cfg);
    assign last_byte = var_mode ? term_hit
                                : (rx_cnt + 8'h01 == len_cfg);
    assign rx_store  = (rx_state == ASRS_RX_RUN) & rx_perm & rx_valid
                     & ~ovf_hit;
    assign tmo_hit   = got_first ? ((ict_lim != 16'h0000)
                                    & (gap > {1'b0, ict_lim}))
                                 : ((fct_lim != 16'h0000)
                                    & (gap > {1'b0, fct_lim}));

    // Register writes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl     <= ASRS_RST_WORD;
            rx_cfg   <= ASRS_RST_WORD;
            term_cfg <= ASRS_RST_WORD;
            tmo_cfg  <= ASRS_RST_WORD;
            map0     <= ASRS_RST_WORD;
            map1     <= ASRS_RST_WORD;
            scfg     <= ASRS_RST_WORD;
            pat0     <= ASRS_RST_WORD;
            pat1     <= ASRS_RST_WORD;
        end else if (bus_wr) begin
            case (widx)
                ASRS_REG_CTRL:  ctrl     <= merge(ctrl, wb_dat_i, wb_sel_i);
                ASRS_REG_RXCFG: rx_cfg   <= merge(rx_cfg, wb_dat_i, wb_sel_i);
                ASRS_REG_TERM:  term_cfg <= merge(term_cfg, wb_dat_i, wb_sel_i);
                ASRS_REG_TMO:   tmo_cfg  <= merge(tmo_cfg, wb_dat_i, wb_sel_i);
                ASRS_REG_MAP0:  map0     <= merge(map0, wb_dat_i, wb_sel_i);
                ASRS_REG_MAP1:  map1     <= merge(map1, wb_dat_i, wb_sel_i);
                ASRS_REG_SCFG:  scfg     <= merge(scfg, wb_dat_i, wb_sel_i);
                ASRS_REG_PAT0:  pat0     <= merge(pat0, wb_dat_i, wb_sel_i);
                ASRS_REG_PAT1:  pat1     <= merge(pat1, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // Bus answer: ack one cycle after request, reads registered
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ASRS_RST_WORD;
        end else begin
            wb_ack_o <= access;
            if (access & ~wb_we_i) begin
                if (mem_hit) begin
                    wb_dat_o <= {16'h0000, mem[{bank, widx[5:0]}]};
                end else begin
                    case (widx)
                        ASRS_REG_CTRL:   wb_dat_o <= ctrl;
                        ASRS_REG_RXCFG:  wb_dat_o <= rx_cfg;
                        ASRS_REG_TERM:   wb_dat_o <= term_cfg;
                        ASRS_REG_TMO:    wb_dat_o <= tmo_cfg;
                        ASRS_REG_STATUS: wb_dat_o <= {rx_cnt, 13'h0000,
                            bank, search_done, (sr_state == ASRS_SR_SCAN),
                            invalid_value_flag, cannot_execute_flag,
                            port_two_active_flag, fct_err, overflow_flag,
                            ict_err, complete_flag, busy_flag};
                        ASRS_REG_MAP0:   wb_dat_o <= map0;
                        ASRS_REG_MAP1:   wb_dat_o <= map1;
                        ASRS_REG_SCFG:   wb_dat_o <= scfg;
                        ASRS_REG_PAT0:   wb_dat_o <= pat0;
                        ASRS_REG_PAT1:   wb_dat_o <= pat1;
                        ASRS_REG_RESULT: wb_dat_o <= {16'h0000, result};
                        default:         wb_dat_o <= ASRS_RST_WORD;
                    endcase
                end
            end
        end
    end

    // String memory: receive fills the idle bank, bus sees the live bank
    always_ff @(posedge clk_sys) begin
        if (rx_store) begin
            if (rx_cnt[0] ^ swap) begin
                mem[{~bank, rx_cnt[6:1]}][15:8] <= rx_data;
            end else begin
                mem[{~bank, rx_cnt[6:1]}][7:0] <= rx_data;
            end
        end
        if (bus_wr & mem_hit & wb_sel_i[0]) begin
            mem[{bank, widx[5:0]}][7:0] <= wb_dat_i[7:0];
        end
        if (bus_wr & mem_hit & wb_sel_i[1]) begin
            mem[{bank, widx[5:0]}][15:8] <= wb_dat_i[15:8];
        end
    end

    // Timeout tick and gap counter
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0
                                                          : tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            gap <= '0;
        end else if ((rx_state != ASRS_RX_RUN) | rx_valid) begin
            gap <= '0;
        end else if (tick & ~&gap) begin
            gap <= gap + 17'h00001;
        end
    end

    // Receive sequencer
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state      <= ASRS_RX_IDLE;
            rx_cnt        <= 8'h00;
            prev_byte     <= 8'h00;
            got_first     <= 1'b0;
            complete_flag <= 1'b0;
            overflow_flag <= 1'b0;
            ict_err       <= 1'b0;
            fct_err       <= 1'b0;
            rx_bad        <= 1'b0;
            bank          <= 1'b0;
        end else if (~rx_perm) begin
            rx_state      <= ASRS_RX_IDLE;
            complete_flag <= 1'b0;
            overflow_flag <= 1'b0;
            ict_err       <= 1'b0;
            fct_err       <= 1'b0;
            rx_bad        <= 1'b0;
        end else begin
            case (rx_state)
                ASRS_RX_IDLE: begin
                    rx_cnt    <= 8'h00;
                    got_first <= 1'b0;
                    if (rx_cfg_bad) begin
                        rx_bad   <= 1'b1;
                        rx_state <= ASRS_RX_HOLD;
                    end else begin
                        rx_state <= ASRS_RX_RUN;
                    end
                end
                ASRS_RX_RUN: begin
                    if (rx_valid) begin
                        got_first <= 1'b1;
                        prev_byte <= rx_data;
                        if (ovf_hit) begin
                            overflow_flag <= 1'b1;
                            rx_state      <= ASRS_RX_HOLD;
                        end else begin
                            rx_cnt <= rx_cnt + 8'h01;
                            if (last_byte) begin
                                complete_flag <= 1'b1;
                                bank          <= ~bank;
                                rx_state      <= ASRS_RX_HOLD;
                            end
                        end
                    end else if (tmo_hit) begin
                        ict_err  <= got_first;
                        fct_err  <= ~got_first;
                        rx_state <= ASRS_RX_HOLD;
                    end
                end
                ASRS_RX_HOLD: ;
                default: rx_state <= ASRS_RX_IDLE;
            endcase
        end
    end

    // Flag outputs and their control bit indices
    assign busy_flag            = (rx_state == ASRS_RX_RUN);
    assign port_two_active_flag = busy_flag & got_first;
    assign timeout_flag         = ict_err | fct_err;
    assign busy_bit_idx         = map0[ASRS_MAP_LO +: ASRS_IDX_W];
    assign complete_bit_idx     = map0[ASRS_MAP_HI +: ASRS_IDX_W];
    assign timeout_bit_idx      = map1[ASRS_MAP_LO +: ASRS_IDX_W];
    assign overflow_bit_idx     = map1[ASRS_MAP_HI +: ASRS_IDX_W];
    assign cannot_execute_flag  = rx_bad | s_bad;
    assign invalid_value_flag   = rx_bad | s_bad;

    // Search parameters and conflict check
    logic [7:0] c_start, c_total, c_word;
    logic [3:0] c_plen;
    logic       c_conflict, srch_start;
    logic [8:0] c_end;
    assign c_start = {1'b0, scfg[ASRS_SCFG_START +: 7]};
    assign c_word  = mem[{bank, scfg[ASRS_SCFG_TWORD +: 6]}][7:0];
    assign c_total = scfg[ASRS_SCFG_TMEM] ? c_word
                                          : scfg[ASRS_SCFG_TOTAL +: 8];
    assign c_plen  = scfg[ASRS_SCFG_PLEN +: 4];
    assign c_end   = {1'b0, c_start} + {5'h00, c_plen};
    assign c_conflict = (c_total == 8'h00)
                      | (c_total > 8'(ASRS_MAX_BYTES))
                      | (c_plen == 4'h0)
                      | (c_plen > 4'(ASRS_PAT_MAX))
                      | (c_end > {1'b0, c_total});
    assign srch_start = ctrl[ASRS_CTRL_SRCH] & ~srch_perm_q;

    // Pattern compare, one lane per pattern byte
    logic [8*ASRS_PAT_MAX-1:0] pats;
    assign pats = {pat1, pat0};
    generate
        for (genvar k = 0; k < ASRS_PAT_MAX; k++) begin : g_lane
            logic [7:0]  bi;
            logic [15:0] w;
            assign bi = s_pos + 8'(k);
            assign w  = mem[{bank, bi[6:1]}];
            assign lane_ok[k] = (4'(k) >= s_plen)
                | ((bi[0] ? w[15:8] : w[7:0]) == pats[8*k +: 8]);
        end
    endgenerate

    // Search sequencer
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sr_state    <= ASRS_SR_IDLE;
            srch_perm_q <= 1'b0;
            s_bad       <= 1'b0;
            s_rev       <= 1'b0;
            s_fend      <= 1'b0;
            s_pos       <= 8'h00;
            s_start     <= 8'h00;
            s_last      <= 8'h00;
            s_plen      <= 4'h0;
            result      <= 16'h0000;
            search_done <= 1'b0;
        end else begin
            srch_perm_q <= ctrl[ASRS_CTRL_SRCH];
            case (sr_state)
                ASRS_SR_IDLE: begin
                    if (srch_start) begin
                        s_bad       <= c_conflict;
                        search_done <= c_conflict;
                        s_rev       <= scfg[ASRS_SCFG_REV];
                        s_fend      <= scfg[ASRS_SCFG_FEND];
                        s_plen      <= c_plen;
                        s_start     <= c_start;
                        s_last      <= c_total - {4'h0, c_plen};
                        s_pos       <= scfg[ASRS_SCFG_REV]
                                     ? c_total - {4'h0, c_plen}
                                     : c_start;
                        if (c_conflict) begin
                            result <= ASRS_CONFLICT;
                        end else begin
                            sr_state <= ASRS_SR_SCAN;
                        end
                    end
                end
                ASRS_SR_SCAN: begin
                    if (&lane_ok) begin
                        result <= {8'h00, s_fend
                                  ? s_pos + {4'h0, s_plen} - 8'h01
                                  : s_pos};
                        search_done <= 1'b1;
                        sr_state    <= ASRS_SR_IDLE;
                    end else if (s_pos == (s_rev ? s_start : s_last)) begin
                        result      <= ASRS_NOT_FOUND;
                        search_done <= 1'b1;
                        sr_state    <= ASRS_SR_IDLE;
                    end else begin
                        s_pos <= s_rev ? s_pos - 8'h01
                                       : s_pos + 8'h01;
                    end
                end
                default: sr_state <= ASRS_SR_IDLE;
            endcase
        end
    end

endmodule

// >>> inc/asrs_pkg.sv
package asrs_pkg;
    // Timing: timeout unit is one tick of 1 ms
    localparam int ASRS_CLK_PERIOD_NS = 25;
    localparam int ASRS_TICK_NS       = 1000000;
    localparam int ASRS_TICK_CYCLES   = ASRS_TICK_NS / ASRS_CLK_PERIOD_NS;

    // Sizes
    localparam int ASRS_MAX_BYTES = 128;
    localparam int ASRS_WORDS     = 64;
    localparam int ASRS_PAT_MAX   = 8;
    localparam int ASRS_IDX_W     = 11;

    // Register word indices (byte address = 4 * index)
    localparam logic [7:0] ASRS_REG_CTRL   = 8'h00;
    localparam logic [7:0] ASRS_REG_RXCFG  = 8'h01;
    localparam logic [7:0] ASRS_REG_TERM   = 8'h02;
    localparam logic [7:0] ASRS_REG_TMO    = 8'h03;
    localparam logic [7:0] ASRS_REG_STATUS = 8'h04;
    localparam logic [7:0] ASRS_REG_MAP0   = 8'h05;
    localparam logic [7:0] ASRS_REG_MAP1   = 8'h06;
    localparam logic [7:0] ASRS_REG_SCFG   = 8'h07;
    localparam logic [7:0] ASRS_REG_PAT0   = 8'h08;
    localparam logic [7:0] ASRS_REG_PAT1   = 8'h09;
    localparam logic [7:0] ASRS_REG_RESULT = 8'h0A;
    localparam logic [1:0] ASRS_MEM_PAGE   = 2'h1;

    // Field positions
    localparam int ASRS_CTRL_RX     = 0;
    localparam int ASRS_CTRL_SRCH   = 1;
    localparam int ASRS_RXCFG_LEN   = 0;
    localparam int ASRS_RXCFG_VAR   = 8;
    localparam int ASRS_RXCFG_SWAP  = 9;
    localparam int ASRS_RXCFG_TERM2 = 10;
    localparam int ASRS_RXCFG_PORT  = 12;
    localparam int ASRS_TERM_T0     = 0;
    localparam int ASRS_TERM_T1     = 8;
    localparam int ASRS_TMO_ICT     = 0;
    localparam int ASRS_TMO_FCT     = 16;
    localparam int ASRS_MAP_LO      = 0;
    localparam int ASRS_MAP_HI      = 16;
    localparam int ASRS_SCFG_START  = 0;
    localparam int ASRS_SCFG_TOTAL  = 8;
    localparam int ASRS_SCFG_PLEN   = 16;
    localparam int ASRS_SCFG_REV    = 20;
    localparam int ASRS_SCFG_FEND   = 21;
    localparam int ASRS_SCFG_TMEM   = 22;
    localparam int ASRS_SCFG_TWORD  = 24;
    localparam int ASRS_ST_RXCNT    = 24;

    // Values
    localparam logic [3:0]  ASRS_PORT_TWO  = 4'h2;
    localparam logic [15:0] ASRS_NOT_FOUND = 16'hFFFF;
    localparam logic [15:0] ASRS_CONFLICT  = 16'hEEEE;
    localparam logic [31:0] ASRS_RST_WORD  = 32'h0000_0000;

    typedef enum logic [2:0] {
        ASRS_RX_IDLE = 3'b001,
        ASRS_RX_RUN  = 3'b010,
        ASRS_RX_HOLD = 3'b100
    } asrs_rx_state_t;

    typedef enum logic [1:0] {
        ASRS_SR_IDLE = 2'b01,
        ASRS_SR_SCAN = 2'b10
    } asrs_sr_state_t;
endpackage

// >>> dv/asrs_src_model.sv
`timescale 1ns/10ps
module asrs_src_model (
    input  wire logic       clk_sys,
    output logic            rx_valid,
    output logic      [7:0] rx_data
);
    // Line idle at start
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end
    // One byte after an idle gap; junk on the data line between bytes
    task send(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
endmodule

// >>> dv/asrs_top_chk.sv
`timescale 1ns/10ps
module asrs_top_chk (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        rx_valid,
    input wire logic        busy_flag,
    input wire logic        complete_flag,
    input wire logic        timeout_flag,
    input wire logic        overflow_flag,
    input wire logic        cannot_execute_flag,
    input wire logic        invalid_value_flag,
    input wire logic        port_two_active_flag
);
    logic rx_perm;
    // Mirror of the receive permit bit
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            rx_perm <= 1'b0;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_adr_i[9:2] == 8'h00 && wb_sel_i[0])
            rx_perm <= wb_dat_i[0];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    done_not_busy_a: assert property (complete_flag |-> !busy_flag)
        else $error("busy with complete");
    err_pair_a: assert property (cannot_execute_flag == invalid_value_flag)
        else $error("error flags differ");
    port_rise_a: assert property ($rose(port_two_active_flag) |-> $past(rx_valid) && busy_flag)
        else $error("port active without byte");
    tmo_hold_a: assert property (rx_perm && timeout_flag ##1 rx_perm |-> timeout_flag)
        else $error("timeout dropped");
    done_hold_a: assert property (rx_perm && complete_flag ##1 rx_perm |-> complete_flag)
        else $error("complete dropped");
    flag_clear_a: assert property (!rx_perm [*2] |-> !(busy_flag || complete_flag || timeout_flag || overflow_flag))
        else $error("flag kept without permit");
    done_cause_a: assert property ($rose(complete_flag) || $rose(overflow_flag) |-> $past(rx_valid))
        else $error("flag set without byte");
endmodule
bind asrs_top asrs_top_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .busy_flag(busy_flag),
    .complete_flag(complete_flag), .timeout_flag(timeout_flag),
    .overflow_flag(overflow_flag), .cannot_execute_flag(cannot_execute_flag),
    .invalid_value_flag(invalid_value_flag),
    .port_two_active_flag(port_two_active_flag));

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    import asrs_pkg::*;
    logic        clk_sys, sys_rst, cyc, stb, we, ack, rx_valid;
    logic        busy, done, tmo, ovf, cant, inval, pact, sdone;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, r;
    logic [7:0]  rx_data, b0;
    logic [10:0] i_busy, i_done, i_tmo, i_ovf;
    logic [31:0] exp_q[$];
    string       nm_q[$];
    int          errors, n_compared, cyc_cnt, seed;
    logic [15:0] txt[8] = '{16'h6F54, 16'h6164, 16'h2079, 16'h7369,
                            16'h4620, 16'h6972, 16'h6164, 16'h2E79};
    logic [31:0] scfg[7] = '{32'h0003_1005, 32'h0003_1000, 32'h0033_1000,
                             32'h0013_0C00, 32'h0003_100D, 32'h0003_0000,
                             32'h0843_0005};
    logic [15:0] res[7] = '{16'h000C, 16'h0002, 16'h000E, 16'h0002,
                            16'hFFFF, 16'hEEEE, 16'h000C};

    asrs_top #(.TICK_CYCLES(4)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_valid(rx_valid), .rx_data(rx_data), .busy_flag(busy),
        .complete_flag(done), .timeout_flag(tmo), .overflow_flag(ovf),
        .busy_bit_idx(i_busy), .complete_bit_idx(i_done),
        .timeout_bit_idx(i_tmo), .overflow_bit_idx(i_ovf),
        .cannot_execute_flag(cant), .invalid_value_flag(inval),
        .port_two_active_flag(pact), .search_done(sdone));
    asrs_src_model src (.clk_sys(clk_sys), .rx_valid(rx_valid),
        .rx_data(rx_data));

    // Clock, 25 ns period
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Classic single cycle; a read leaves its expectation as a note
    task wb(input logic w, input logic [9:0] a, input logic [31:0] d,
            input string nm = "");
        if (!w) begin
            exp_q.push_back(d);
            nm_q.push_back(nm);
        end
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= w ? d : 32'h0;
        @(posedge clk_sys iff ack);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Rearm the receiver with a fresh setup
    task arm(input logic [31:0] cfg, input logic [31:0] t);
        wb(1, 10'h000, 32'h0);
        wb(1, 10'h004, cfg);
        wb(1, 10'h00C, t);
        wb(1, 10'h000, 32'h1);
        repeat (2) @(posedge clk_sys);
    endtask

    task settle;
        for (int i = 0; i < 60 && !(done || tmo || ovf); i++)
            @(posedge clk_sys);
    endtask

    // Read data against the oldest note
    always @(posedge clk_sys) begin
        if (ack && cyc && !we)
            chk(rdat, exp_q.pop_front(), nm_q.pop_front());
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt > 20000) begin
            errors++;
            close_out;
        end
    end

    initial begin
        seed = 32'h33219aa5;
        {cyc, stb, we, adr, dat, errors, n_compared, cyc_cnt} = '0;
        sel = 4'hF;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        r = $random(seed);
        wb(1, 10'h014, {5'h0, r[10:0], 16'h07FF});
        wb(1, 10'h018, {21'h0, r[26:16]});
        chk(i_busy, 32'h7FF, "busy_idx");
        chk(i_done, r[10:0], "done_idx");
        chk(i_tmo, r[26:16], "tmo_idx");
        chk(i_ovf, 32'h0, "ovf_idx");
        wb(0, 10'h0FC, 32'h0, "unmapped");
        // Fixed length, slow source, no timeout selected
        arm(32'h0000_2003, 32'h0);
        chk(busy, 1, "busy");
        r = $random(seed);
        for (int i = 0; i < 3; i++) src.send(r[8*i+:8], 10 * i);
        settle;
        chk(done, 1, "fixed_done");
        wb(0, 10'h010, 32'h0300_0402, "status");
        wb(0, 10'h100, {16'h0, r[15:0]}, "fixed_w0");
        // Variable, swapped, two terminators after a lone first one
        wb(1, 10'h008, 32'h0000_0A0D);
        arm(32'h0000_2708, 32'h0);
        b0 = {2'b01, r[29:24]};
        for (int i = 0; i < 4; i++) src.send(i ? (i == 3 ? 8'h0A : 8'h0D) : b0, i);
        settle;
        chk(done, 1, "var_done");
        wb(0, 10'h100, {16'h0, b0, 8'h0D}, "swap_w0");
        wb(0, 10'h104, 32'h0000_0D0A, "swap_w1");
        // Terminator arriving past the maximum length
        arm(32'h0000_2102, 32'h0);
        for (int i = 0; i < 3; i++) src.send(i == 2 ? 8'h0D : 8'h41, 0);
        settle;
        chk({ovf, done}, 2'b10, "overflow");
        // Gap between characters too long
        arm(32'h0000_2004, 32'h0000_0001);
        src.send(8'h41, 0);
        @(posedge clk_sys);
        chk(pact, 1, "port_active");
        settle;
        chk({tmo, done}, 2'b10, "gap_tmo");
        wb(0, 10'h100, {16'h0, b0, 8'h0D}, "kept_w0");
        // Variable, single terminator ends the string
        arm(32'h0000_2102, 32'h0);
        for (int i = 0; i < 2; i++) src.send(i ? 8'h0D : 8'h41, 0);
        settle;
        chk(done, 1, "one_term");
        wb(0, 10'h100, 32'h0000_0D41, "one_w0");
        // No first character at all
        arm(32'h0000_2004, 32'h0002_0000);
        settle;
        chk(tmo, 1, "first_tmo");
        wb(1, 10'h000, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk(tmo, 0, "tmo_clear");
        // Wrong port number refused
        arm(32'h0000_3004, 32'h0);
        chk({cant, inval, busy}, 3'b110, "bad_port");
        // Search table over a known string
        wb(1, 10'h000, 32'h0);
        for (int i = 0; i < 8; i++) wb(1, 10'(10'h100 + 4 * i), {16'h0, txt[i]});
        wb(1, 10'h020, 32'h0079_6164);
        wb(1, 10'h120, 32'h0000_0010); // Total for the memory case
        for (int i = 0; i < 7; i++) begin
            wb(1, 10'h01C, scfg[i]);
            wb(1, 10'h000, 32'h0);
            wb(1, 10'h000, 32'h2);
            @(posedge clk_sys);
            for (int k = 0; k < 40 && !sdone; k++) @(posedge clk_sys);
            chk(sdone, 1, "search_done");
            wb(0, 10'h028, {16'h0, res[i]}, "result");
            chk(cant, i == 5, "conflict");
        end
        close_out;
    end
endmodule
